// File: spp_link_model.sv
`timescale 1ns/1ns
module spp_link_model (
  input  wire logic          clk,
  input  wire logic          sendReq,
  input  spp_pkg::spp_word_t word,
  output logic               txClk,
  output spp_pkg::spp_word_t txWord,
  output logic               busy
);
  import spp_pkg::*;
  // rate and mode straps are fixed on the controller board, no pins here
  // clock stands still between words; a released bus shows the inverse
  initial begin
    txClk  = 1'b0;
    txWord = '0;
    busy   = 1'b0;
    forever begin
      @(posedge clk);
      if (sendReq) begin
        @(negedge clk);
        busy   = 1'b1;
        txWord = word;
        repeat (4) @(negedge clk);
        txClk = 1'b1;
        repeat (4) @(negedge clk);
        txClk = 1'b0;
        repeat (4) @(negedge clk);
        txWord = ~word;
        busy   = 1'b0;
      end
    end
  end
endmodule

// File: spp_pipe_port.sv
// Contract
// R1: tx word holds two symbols, low first
// R2: each tx byte has own control flag
// R3: controller drives tx on its clock edge
// R4: device drives parallel clock for rx side
// R5: rx word holds two symbols, low first
// R6: rx flag: zero data, one control
// R7: rx valid only with symbol lock
// R8: phy reset clears logic asynchronously
// R9: detect request starts detect or loopback
// R10: idle request forces transmit electrical idle
// R11: three-bit receive status code reported
// R12: no underflow code in nominal-empty mode
// R13: two-bit code selects power state P0-P3
// R14: P3 to P0 signaling is asynchronous
// R15: done flag marks power, rate, detect completion; no rate change here, so the flag marks power and detect only
// R16: done flag sampled asynchronously around P3
// R17: ones-zeros sends alternating runs, ignores data
// R18: de-emphasis code applied within 128 ns
// R19: margin code and swing set level
// R20: polarity input inverts received data
// R21: termination input adds or removes terminations
// R22: rate and mode pins held fixed
// R23: done flag pulses one cycle per operation
`timescale 1ns/1ns
module spp_pipe_port (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          clkEn,
  input  wire logic          phyAsyncResetN,
  input  wire logic          txClk,
  input  spp_pkg::spp_word_t txWordIn,
  input  wire logic          detectOrLoopbackRequest,
  input  wire logic          transmitIdleForce,
  input  wire logic          alternatingRunsRequest,
  input  wire logic [1:0]    deemphasisSelect,
  input  wire logic [2:0]    voltageLevelSelect,
  input  wire logic          swingHalf,
  input  wire logic          rxPolarity,
  input  wire logic          receiverTerminationControl,
  input  spp_pkg::spp_pwr_t  powerDown,
  input  spp_pkg::spp_sym_t  lineRxSym,
  input  wire logic          lineRxValid,
  input  wire logic          lineRxLock,
  input  wire logic [2:0]    lineRxCode,
  input  wire logic          lineRxIdle,
  input  wire logic          receiverPresent,
  input  wire logic          elasNominalEmpty,
  output logic               pclk,
  output spp_pkg::spp_word_t rxWord,
  output logic               rxValid,
  output logic [2:0]         rxStatus,
  output logic               operationDoneFlag,
  output logic               receiveIdleIndicator,
  output spp_pkg::spp_sym_t  lineTxSym,
  output logic               lineTxValid,
  output logic               lineTxIdle,
  output logic               lineRunBit,
  output logic               lineRunsActive,
  output logic               loopbackActive,
  output spp_pkg::spp_pwr_t  powerState,
  output logic [1:0]         appliedDeemph,
  output logic [2:0]         appliedMargin,
  output logic               appliedSwing,
  output logic               termEnable
);
  import spp_pkg::*;

  localparam int DEEMPH_WAIT = DEEMPH_CYC;

  function automatic logic [2:0] filtCode(input logic [2:0] code, input logic nomEmpty);
    return (nomEmpty && code == ST_UNDERFLOW) ? ST_OK : code;
  endfunction

  function automatic spp_sym_t invSym(input spp_sym_t s, input logic inv);
    spp_sym_t r;
    r      = s;
    r.data = s.data ^ {8{inv}};
    return r;
  endfunction

  logic      rstN;
  spp_pins_t pinRaw;
  spp_pins_t pinA_q;
  spp_pins_t pinB_q;

  // both resets act without a clock
  assign rstN = arst_n & phyAsyncResetN; // see R8

  // every control pin, tx clock and tx bus included, is foreign to clk
  assign pinRaw = {txClk, txWordIn, detectOrLoopbackRequest, transmitIdleForce,
                   alternatingRunsRequest, deemphasisSelect, voltageLevelSelect,
                   swingHalf, rxPolarity, receiverTerminationControl, powerDown};

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinA_q <= '0;
      pinB_q <= '0;
    end else if (clkEn) begin
      pinA_q <= pinRaw;
      pinB_q <= pinA_q;
    end
  end

  // power and detect group
  spp_pwr_t   pwr_q;
  spp_pwr_t   pwr_d;
  spp_pwr_t   target_q;
  spp_pwr_t   target_d;
  logic [3:0] pwrCnt_q;
  logic [3:0] pwrCnt_d;
  logic [4:0] detCnt_q;
  logic [4:0] detCnt_d;
  logic       detPrev_q;
  logic       done_q;
  logic       done_d;
  logic       pclk_q;
  logic       pclk_d;
  logic       pwrBusy;
  logic       detBusy;
  logic       pwrStart;
  logic       detStart;
  logic       pwrDone;
  logic       detDone;

  always_comb begin
    pwrBusy  = pwrCnt_q != 4'h0;
    detBusy  = detCnt_q != 5'h0;
    pwrStart = !pwrBusy && !detBusy && pinB_q.pwrSel != pwr_q; // see R13
    // detection only from P2; in P0 the same request means loopback
    detStart = !pwrBusy && !detBusy && pinB_q.detReq && !detPrev_q
               && pwr_q == SPP_P2; // see R9
    pwrDone  = pwrCnt_q == 4'h1;
    detDone  = detCnt_q == 5'h1;
    pwr_d    = pwrDone ? target_q : pwr_q;
    target_d = pwrStart ? pinB_q.pwrSel : target_q;
    pwrCnt_d = pwrStart ? PWR_LOAD : (pwrBusy ? pwrCnt_q - 4'h1 : pwrCnt_q);
    detCnt_d = detStart ? DET_LOAD : (detBusy ? detCnt_q - 5'h1 : detCnt_q);
    done_d   = pwrDone || detDone; // see R15, R16
    // parallel clock halts in P3; the done pulse still runs on clk
    pclk_d   = (pwr_q == SPP_P3) ? 1'b0 : ~pclk_q; // see R4, R14
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pwr_q     <= SPP_P0;
      target_q  <= SPP_P0;
      pwrCnt_q  <= '0;
      detCnt_q  <= '0;
      detPrev_q <= 1'b0;
      done_q    <= 1'b0;
      pclk_q    <= 1'b0;
    end else if (clkEn) begin
      pwr_q     <= pwr_d;
      target_q  <= target_d;
      pwrCnt_q  <= pwrCnt_d;
      detCnt_q  <= detCnt_d;
      detPrev_q <= pinB_q.detReq;
      done_q    <= done_d;
      pclk_q    <= pclk_d;
    end
  end

  // transmit group
  logic      txClkPrev_q;
  spp_word_t txHold_q;
  spp_word_t txHold_d;
  spp_txph_t txPh_q;
  spp_txph_t txPh_d;
  spp_sym_t  txSym_q;
  spp_sym_t  txSym_d;
  logic      txValid_q;
  logic      txValid_d;
  logic      txIdle_q;
  logic      txIdle_d;
  logic      txCapture;
  logic      loopOn;
  logic      runsOn;

  always_comb begin
    runsOn    = pinB_q.runsReq;
    loopOn    = pinB_q.detReq && pwr_q == SPP_P0 && !pwrBusy; // see R9
    txCapture = pinB_q.txClk && !txClkPrev_q && pwr_q == SPP_P0
                && !runsOn && !loopOn && !pinB_q.idleForce; // see R3
    txHold_d  = txHold_q;
    txPh_d    = txPh_q;
    txSym_d   = txSym_q;
    txValid_d = 1'b0;
    txIdle_d  = pinB_q.idleForce || pwr_q != SPP_P0; // see R10
    case (txPh_q)
      TX_LOW: begin
        txSym_d   = '{k: txHold_q.flags[0], data: txHold_q.data[7:0]}; // see R1
        txValid_d = 1'b1;
        txPh_d    = TX_HIGH;
      end
      TX_HIGH: begin
        txSym_d   = '{k: txHold_q.flags[1], data: txHold_q.data[15:8]}; // see R2
        txValid_d = 1'b1;
        txPh_d    = TX_IDLE;
      end
      default: begin
        txPh_d = TX_IDLE;
      end
    endcase
    if (txCapture) begin
      txHold_d = pinB_q.txWord;
      txPh_d   = TX_LOW;
    end
    if (runsOn) begin
      txPh_d    = TX_IDLE; // see R17
      txValid_d = 1'b0;
    end
    if (loopOn) begin
      txSym_d   = lineRxSym;
      txValid_d = lineRxValid;
      txPh_d    = TX_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txClkPrev_q <= 1'b0;
      txHold_q    <= '0;
      txPh_q      <= TX_IDLE;
      txSym_q     <= '0;
      txValid_q   <= 1'b0;
      txIdle_q    <= 1'b1;
    end else if (clkEn) begin
      txClkPrev_q <= pinB_q.txClk;
      txHold_q    <= txHold_d;
      txPh_q      <= txPh_d;
      txSym_q     <= txSym_d;
      txValid_q   <= txValid_d;
      txIdle_q    <= txIdle_d;
    end
  end

  spp_runs_gen u_runs (
    .clk       (clk),
    .arst_n    (rstN),
    .clkEn     (clkEn),
    .enable    (runsOn),
    .runBit    (lineRunBit),
    .runActive (lineRunsActive)
  );

  // receive and configuration group
  logic      rxHalf_q;
  logic      rxHalf_d;
  spp_sym_t  rxLow_q;
  spp_sym_t  rxLow_d;
  logic [2:0] statLow_q;
  logic [2:0] statLow_d;
  spp_word_t rxWord_q;
  spp_word_t rxWord_d;
  logic      rxValid_q;
  logic      rxValid_d;
  logic [2:0] rxStatus_q;
  logic [2:0] rxStatus_d;
  logic [1:0] deemph_q;
  logic [1:0] deemph_d;
  logic [2:0] margin_q;
  logic       swing_q;
  logic       term_q;
  logic       rxIdle_q;
  spp_sym_t  rxSym;
  logic [2:0] curCode;
  logic      pairDone;

  always_comb begin
    rxSym      = invSym(lineRxSym, pinB_q.polarity); // see R20
    curCode    = filtCode(lineRxCode, elasNominalEmpty); // see R12
    pairDone   = lineRxValid && lineRxLock && rxHalf_q;
    rxHalf_d   = rxHalf_q;
    rxLow_d    = rxLow_q;
    statLow_d  = statLow_q;
    rxWord_d   = rxWord_q;
    rxValid_d  = rxValid_q;
    rxStatus_d = rxStatus_q;
    if (!lineRxLock) begin
      rxHalf_d  = 1'b0;
      rxValid_d = 1'b0; // see R7
    end else if (lineRxValid) begin
      if (!rxHalf_q) begin
        rxLow_d   = rxSym; // see R6
        statLow_d = curCode;
        rxHalf_d  = 1'b1;
      end else begin
        rxWord_d   = '{flags: {rxSym.k, rxLow_q.k}, data: {rxSym.data, rxLow_q.data}}; // see R5
        // an error on the first byte outranks a clean second byte
        rxStatus_d = (statLow_q != ST_OK) ? statLow_q : curCode; // see R11
        rxValid_d  = 1'b1;
        rxHalf_d   = 1'b0;
      end
    end
    if (detDone && receiverPresent) begin
      rxStatus_d = ST_RXDET; // see R11
    end
    // reserved code keeps the last good setting
    deemph_d = (pinB_q.deemph == DE_RSV) ? deemph_q : pinB_q.deemph; // see R18
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxHalf_q   <= 1'b0;
      rxLow_q    <= '0;
      statLow_q  <= ST_OK;
      rxWord_q   <= '0;
      rxValid_q  <= 1'b0;
      rxStatus_q <= ST_OK;
      deemph_q   <= DEEMPH_RST;
      margin_q   <= MARGIN_RST;
      swing_q    <= 1'b0;
      term_q     <= 1'b0;
      rxIdle_q   <= 1'b1;
    end else if (clkEn) begin
      rxHalf_q   <= rxHalf_d;
      rxLow_q    <= rxLow_d;
      statLow_q  <= statLow_d;
      rxWord_q   <= rxWord_d;
      rxValid_q  <= rxValid_d;
      rxStatus_q <= rxStatus_d;
      deemph_q   <= deemph_d;
      margin_q   <= pinB_q.margin; // see R19
      swing_q    <= pinB_q.swing; // see R19
      term_q     <= pinB_q.term; // see R21
      rxIdle_q   <= lineRxIdle;
    end
  end

  assign pclk                 = pclk_q;
  assign rxWord               = rxWord_q;
  // gated so a lost lock drops valid in the same cycle
  assign rxValid              = rxValid_q & lineRxLock; // see R7
  assign rxStatus             = rxStatus_q;
  assign operationDoneFlag    = done_q; // see R23
  assign receiveIdleIndicator = rxIdle_q;
  assign lineTxSym            = txSym_q;
  assign lineTxValid          = txValid_q;
  assign lineTxIdle           = txIdle_q;
  assign loopbackActive       = loopOn;
  assign powerState           = pwr_q;
  assign appliedDeemph        = deemph_q;
  assign appliedMargin        = margin_q;
  assign appliedSwing         = swing_q;
  assign termEnable           = term_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  sequence s_low_out;
    txValid_q && txSym_q.data == $past(pinB_q.txWord.data[7:0], 2);
  endsequence
  sequence s_high_out;
    txValid_q && txSym_q.data == $past(pinB_q.txWord.data[15:8], 3);
  endsequence
  sequence s_flag_out;
    txSym_q.k == $past(pinB_q.txWord.flags[0], 2)
    ##1 txSym_q.k == $past(pinB_q.txWord.flags[1], 3);
  endsequence

  a_tx_order: assert property ((clkEn && txCapture) |-> ##2 s_low_out ##1 s_high_out) // see R1
    else $error("transmit bytes not sent low then high");
  a_tx_flags: assert property ((clkEn && txCapture) |-> ##2 s_flag_out) // see R2
    else $error("transmit flag does not follow its byte");
  a_done_pulse: assert property ((clkEn && done_q) |=> !done_q) // see R23
    else $error("done flag longer than one cycle");
  a_pwr_done: assert property ((clkEn && pwrDone) |=> (done_q && pwr_q == $past(target_q))) // see R13
    else $error("power state not entered with done pulse");
  a_detect_done: assert property ((clkEn && detDone && receiverPresent)
    |=> (done_q && rxStatus_q == ST_RXDET)) // see R15
    else $error("detect completion not reported");
  a_valid_lock: assert property ((clkEn && !lineRxLock) |=> !rxValid_q) // see R7
    else $error("receive valid without lock");
  a_no_underflow: assert property ((clkEn && pairDone && elasNominalEmpty
    && $past(elasNominalEmpty)) |=> rxStatus_q != ST_UNDERFLOW) // see R12
    else $error("underflow code in nominal-empty mode");
  a_rx_polarity: assert property ((clkEn && pairDone) |=> rxWord_q.data[15:8]
    == ($past(pinB_q.polarity) ? ~$past(lineRxSym.data) : $past(lineRxSym.data))) // see R20
    else $error("receive polarity not applied");
  a_idle_force: assert property ((clkEn && pinB_q.idleForce) |=> txIdle_q) // see R10
    else $error("transmit idle not forced");
  a_deemph_apply: assert property ((clkEn && pinB_q.deemph != deemph_q
    && pinB_q.deemph != DE_RSV) |-> ##[1:DEEMPH_WAIT] deemph_q == pinB_q.deemph) // see R18
    else $error("de-emphasis not applied in time");
  a_runs_mute: assert property ((clkEn && pinB_q.runsReq) |=> !txValid_q) // see R17
    else $error("transmit data sent during ones-zeros runs");
  a_pclk_stop: assert property ((clkEn && pwr_q == SPP_P3) |=> !pclk_q) // see R14
    else $error("parallel clock runs in P3");
  a_term_follow: assert property (clkEn |=> termEnable == $past(pinB_q.term)) // see R21
    else $error("termination does not follow its input");

endmodule

// File: spp_pkg.sv
package spp_pkg;

  localparam int CLK_MHZ    = 100;
  localparam int DEEMPH_NS  = 128;
  // longest time: rounds down
  localparam int DEEMPH_CYC = (DEEMPH_NS * CLK_MHZ) / 1000;

  localparam int RUN_MIN = 50;
  localparam int RUN_MAX = 250;
  localparam int RUN_LEN = 100;
  localparam logic [7:0] RUN_LAST = 8'(RUN_LEN - 1);

  localparam int PWR_SETTLE_CYC = 8;
  localparam int DETECT_CYC     = 16;
  localparam logic [3:0] PWR_LOAD = 4'(PWR_SETTLE_CYC);
  localparam logic [4:0] DET_LOAD = 5'(DETECT_CYC);

  localparam logic [2:0] ST_OK        = 3'h0;
  localparam logic [2:0] ST_SKP_ADD   = 3'h1;
  localparam logic [2:0] ST_SKP_DEL   = 3'h2;
  localparam logic [2:0] ST_RXDET     = 3'h3;
  localparam logic [2:0] ST_DECODE    = 3'h4;
  localparam logic [2:0] ST_OVERFLOW  = 3'h5;
  localparam logic [2:0] ST_UNDERFLOW = 3'h6;
  localparam logic [2:0] ST_DISPARITY = 3'h7;

  localparam logic [1:0] DE_6DB  = 2'h0;
  localparam logic [1:0] DE_3P5  = 2'h1;
  localparam logic [1:0] DE_NONE = 2'h2;
  localparam logic [1:0] DE_RSV  = 2'h3;

  localparam logic [1:0] DEEMPH_RST = DE_6DB;
  localparam logic [2:0] MARGIN_RST = 3'h0;

  typedef enum logic [1:0] {
    SPP_P0 = 2'b00,
    SPP_P1 = 2'b01,
    SPP_P2 = 2'b10,
    SPP_P3 = 2'b11
  } spp_pwr_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOW  = 2'b01,
    TX_HIGH = 2'b10
  } spp_txph_t;

  typedef struct packed {
    logic       k;
    logic [7:0] data;
  } spp_sym_t;

  typedef struct packed {
    logic [1:0]  flags;
    logic [15:0] data;
  } spp_word_t;

  typedef struct packed {
    logic       txClk;
    spp_word_t  txWord;
    logic       detReq;
    logic       idleForce;
    logic       runsReq;
    logic [1:0] deemph;
    logic [2:0] margin;
    logic       swing;
    logic       polarity;
    logic       term;
    spp_pwr_t   pwrSel;
  } spp_pins_t;

endpackage

// File: spp_runs_gen.sv
`timescale 1ns/1ns
module spp_runs_gen (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic clkEn,
  input  wire logic enable,
  output logic      runBit,
  output logic      runActive
);
  import spp_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       bit_q;
  logic       bit_d;
  logic       act_q;
  logic       act_d;

  always_comb begin
    cnt_d = cnt_q;
    bit_d = bit_q;
    act_d = enable;
    if (!enable) begin
      cnt_d = '0;
      bit_d = 1'b1;
    end else if (cnt_q == RUN_LAST) begin
      cnt_d = '0;
      bit_d = ~bit_q; // see R17
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      bit_q <= 1'b1;
      act_q <= 1'b0;
    end else if (clkEn) begin
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      act_q <= act_d;
    end
  end

  assign runBit    = bit_q;
  assign runActive = act_q;

  a_run_flip: assert property (@(posedge clk) disable iff (!arst_n) // see R17
    (clkEn && enable && cnt_q == RUN_LAST) |=> (runBit != $past(runBit)))
    else $error("run did not flip after its full length");

endmodule

// File: tb.sv
`timescale 1ns/1ns
module tb;
  import spp_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, phyRstN = 1'b1;
  spp_pins_t   pins = '0;
  spp_sym_t    rxSym = '0, txSym;
  logic        rxV = 1'b0, rxLock = 1'b0, rxIdle = 1'b0, present = 1'b0, nomEmpty = 1'b0;
  logic [2:0]  rxCode = 3'h0, aMar, rxStatus;
  logic        sendReq = 1'b0, txClk, mBusy, pclk, rxValid, done, idleInd;
  logic        txValid, txIdle, runBit, runsAct, lpbk, aSw, term;
  logic [1:0]  aDe;
  logic        en = 1'b1;
  spp_word_t   sendWord = '0, txWord, rxWord;
  spp_pwr_t    pState;
  logic [31:0] seed = 32'h000086af;
  int          errors = 0, checked = 0, cycles = 0;
  logic [8:0]  txQ[$];
  logic [21:0] rxQ[$];
  logic [5:0]  doneQ[$];
  logic        half = 1'b0, lastDone = 1'b0;
  logic [1:0]  due = 2'h0;

  always #5 clk = ~clk;

  spp_link_model link_u (.clk(clk), .sendReq(sendReq), .word(sendWord), .txClk(txClk),
    .txWord(txWord), .busy(mBusy));
  spp_pipe_port dut_u (
    .clk(clk), .arst_n(arst_n), .clkEn(en), .phyAsyncResetN(phyRstN), .txClk(txClk),
    .txWordIn(txWord), .detectOrLoopbackRequest(pins.detReq),
    .transmitIdleForce(pins.idleForce), .alternatingRunsRequest(pins.runsReq),
    .deemphasisSelect(pins.deemph), .voltageLevelSelect(pins.margin), .swingHalf(pins.swing),
    .rxPolarity(pins.polarity), .receiverTerminationControl(pins.term),
    .powerDown(pins.pwrSel), .lineRxSym(rxSym), .lineRxValid(rxV), .lineRxLock(rxLock),
    .lineRxCode(rxCode), .lineRxIdle(rxIdle), .receiverPresent(present),
    .elasNominalEmpty(nomEmpty), .pclk(pclk), .rxWord(rxWord), .rxValid(rxValid),
    .rxStatus(rxStatus), .operationDoneFlag(done), .receiveIdleIndicator(idleInd),
    .lineTxSym(txSym), .lineTxValid(txValid), .lineTxIdle(txIdle), .lineRunBit(runBit),
    .lineRunsActive(runsAct), .loopbackActive(lpbk), .powerState(pState),
    .appliedDeemph(aDe), .appliedMargin(aMar), .appliedSwing(aSw), .termEnable(term));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic rstChk();
    chk({rxWord, aDe, aMar, aSw, term, txIdle, pclk, rxValid, done, pState}, {18'h0, 13'h020});
  endtask

  // the model needs a cycle to raise busy, so poll only after that
  task automatic sendTx(input logic [31:0] r, input logic take);
    sendWord = r[17:0];
    if (take) begin
      txQ.push_back({r[16], r[7:0]});
      txQ.push_back({r[17], r[15:8]});
    end
    sendReq = 1'b1;
    tick(1);
    sendReq = 1'b0;
    tick(1);
    for (int i = 0; i < 30 && mBusy !== 1'b0; i++) tick(1);
    tick(6);
  endtask

  // second symbol carries a clean code so the first one decides the status
  task automatic rxPair(input logic [31:0] r, input logic [2:0] c);
    logic [2:0] s;
    s = (c == ST_UNDERFLOW && nomEmpty) ? ST_OK : c;
    rxQ.push_back({r[17:16], r[15:0] ^ {16{pins.polarity}}, s, 1'b1});
    rxIdle = r[20];
    rxLock = 1'b1;
    rxV    = 1'b1;
    rxSym  = {r[16], r[7:0]};
    rxCode = c;
    tick(1);
    chk(idleInd, rxIdle);
    rxSym  = {r[17], r[15:8]};
    rxCode = ST_OK;
    tick(1);
    rxV   = 1'b0;
    rxSym = ~rxSym;
    tick(1);
  endtask

  task automatic waitDone();
    for (int i = 0; i < 60 && doneQ.size() > 0; i++) tick(1);
    chk(doneQ.size(), 0);
  endtask

  always @(posedge clk) begin
    due  <= {due[0], rxV & rxLock & half};
    half <= rxLock & (half ^ rxV);
    cycles++;
    if (cycles == 6000) begin
      errors++;
      give_verdict();
    end
  end

  always @(negedge clk) begin
    if (due[1]) chk({rxWord, rxStatus, rxValid}, rxQ.pop_front());
    if (txValid === 1'b1) chk(txSym, txQ.size() ? 32'(txQ.pop_front()) : 32'hffffffff);
    if (done === 1'b1) begin
      chk(lastDone, 1'b0);
      chk(doneQ.size() > 0, 1'b1);
      if (doneQ.size() > 0) begin
        chk(pState, doneQ[0][4:3]);
        if (doneQ[0][5]) chk(rxStatus, doneQ[0][2:0]);
        void'(doneQ.pop_front());
      end
    end
    lastDone = done;
  end

  initial begin
    logic [31:0] r;
    logic [1:0]  de;
    logic        v;
    int          n;
    de = DEEMPH_RST;
    tick(7);
    rstChk();
    tick(1);
    arst_n = 1'b1;
    tick(4);
    v = pclk;
    tick(1);
    chk(pclk, !v);
    for (int i = 0; i < 6; i++) sendTx(rnd(), 1'b1);
    pins.idleForce = 1'b1;
    tick(4);
    chk(txIdle, 1'b1);
    sendTx(rnd(), 1'b0);
    pins.idleForce = 1'b0;
    pins.runsReq = 1'b1;
    tick(6);
    chk(runsAct, 1'b1);
    for (int k = 0; k < 3; k++) begin
      v = runBit;
      for (n = 0; n < 300 && runBit === v; n++) tick(1);
      if (k > 0) chk(n, RUN_LEN);
    end
    sendTx(rnd(), 1'b0);
    pins.runsReq = 1'b0;
    tick(8);
    pins.detReq = 1'b1;
    tick(6);
    chk(lpbk, 1'b1);
    r = rnd();
    rxSym = r[8:0];
    rxV = 1'b1;
    txQ.push_back(r[8:0]);
    tick(1);
    rxV = 1'b0;
    tick(1);
    sendTx(rnd(), 1'b0);
    pins.detReq = 1'b0;
    tick(6);
    chk(lpbk, 1'b0);
    for (int p = 0; p < 2; p++) begin
      pins.polarity = p[0];
      tick(40);
      for (int i = 0; i < 10; i++) begin
        nomEmpty = (i > 7);
        rxPair(rnd(), (i > 7) ? ST_UNDERFLOW : 3'(i));
      end
    end
    tick(1);
    rxLock = 1'b0;
    #1 chk(rxValid, 1'b0);
    for (int p = 1; p < 5; p++) begin
      pins.pwrSel = spp_pwr_t'(p[1:0]);
      doneQ.push_back({1'b0, p[1:0], 3'h0});
      waitDone();
      if (p == 2) begin
        // absent receiver must leave the last status alone
        for (int d = 0; d < 2; d++) begin
          present = d[0];
          pins.detReq = 1'b1;
          doneQ.push_back({1'b1, 2'h2, d[0] ? ST_RXDET : ST_OK});
          waitDone();
          pins.detReq = 1'b0;
          tick(4);
        end
      end
      for (int i = 0; i < 4 && p == 3; i++) begin
        tick(1);
        chk(pclk, 1'b0);
      end
    end
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      pins.deemph = (i == 1) ? DE_RSV : r[1:0];
      pins.margin = r[4:2];
      pins.swing  = r[5];
      pins.term   = r[6];
      if (pins.deemph != DE_RSV) de = pins.deemph;
      tick(DEEMPH_CYC);
      chk(aDe, de);
      chk({aSw, aMar}, r[5:2]);
      chk(term, r[6]);
    end
    en = 1'b0;
    v  = pclk;
    tick(4);
    chk(pclk, v);
    en = 1'b1;
    tick(1);
    chk(pclk, !v);
    phyRstN = 1'b0;
    #2 rstChk();
    tick(2);
    phyRstN = 1'b1;
    tick(4);
    chk(txQ.size() + rxQ.size() + doneQ.size(), 0);
    give_verdict();
  end
endmodule
